// [hw/lcgis_top.sv]
// Gate input select stage of a logic cell with APB register access
// How it works
// - gate one, bit 7 is data four true
// - gate two same layout, high bit true
// - gate three bits one,zero take data one
// - gate four bits five,four take data three
// - set bit includes, clear bit excludes candidate
// - inverted candidate complements true; separate enables
// - select bits read/write, kept through resets
// - each data from 3-bit selector, eight sources
`timescale 1ns/100ps
module lcgis_top (
  input  wire logic                          clk_sys,
  input  wire logic                          rst_n,
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [lcgis_pkg::ADDR_W-1:0]  paddr,
  input  wire logic [lcgis_pkg::DATA_W-1:0]  pwdata,
  input  wire logic [3:0]                    pstrb,
  output logic      [lcgis_pkg::DATA_W-1:0]  prdata,
  output logic                               pready,
  output logic                               pslverr,
  input  wire logic [lcgis_pkg::SRC_W-1:0]   cell_input_sources,
  output logic                               gate_one_out,
  output logic                               gate_two_out,
  output logic                               gate_three_out,
  output logic                               gate_four_out
);
  import lcgis_pkg::*;
  logic [SEL_W-1:0]    gsel_r   [NUM_GATES];
  logic [SEL_W-1:0]    gsel_nxt [NUM_GATES];
  logic [15:0]         dsel_r;
  logic [15:0]         dsel_nxt;
  logic [DATA_W-1:0]   prdata_r;
  logic [DATA_W-1:0]   prdata_nxt;
  logic                pslverr_r;
  logic                pslverr_nxt;
  logic [NUM_DATA-1:0] d_true;
  logic [NUM_DATA-1:0] d_inv;
  logic [NUM_GATES-1:0] g_out;
  logic                acc;
  logic                wr;
  logic                setup;
  logic [2:0]          ridx;

  // Map a byte address to a register index, 7 when unmapped
  function automatic logic [2:0] reg_index(input logic [ADDR_W-1:0] a);
    logic [2:0] r;
    r = 3'h7;
    if (a == GATE1_SEL_ADDR) begin
      r = 3'h0;
    end else if (a == GATE2_SEL_ADDR) begin
      r = 3'h1;
    end else if (a == GATE3_SEL_ADDR) begin
      r = 3'h2;
    end else if (a == GATE4_SEL_ADDR) begin
      r = 3'h3;
    end else if (a == DATA_SEL_ADDR) begin
      r = 3'h4;
    end else if (a == GATE_OUT_ADDR) begin
      r = 3'h5;
    end
    return r;
  endfunction

  // Setup and access phases, single-cycle answer
  assign setup  = psel & ~penable;
  assign acc    = psel & penable;
  assign wr     = acc & pwrite;
  assign pready = 1'b1;
  assign prdata = prdata_r;
  assign pslverr = pslverr_r;

  // Writes land in the access phase; read data and error are
  // latched in the setup phase so they stand while pready is high
  always_comb begin
    ridx        = reg_index(paddr);
    gsel_nxt    = gsel_r;
    dsel_nxt    = dsel_r;
    prdata_nxt  = prdata_r;
    pslverr_nxt = 1'b0;
    case (ridx)
      3'h0, 3'h1, 3'h2, 3'h3: begin
        if (wr && pstrb[0]) begin
          gsel_nxt[ridx[1:0]] = pwdata[SEL_W-1:0];
        end
        if (setup) begin
          prdata_nxt = {24'h0, gsel_r[ridx[1:0]]};
        end
      end
      3'h4: begin
        if (wr && pstrb[0]) begin
          dsel_nxt[7:0] = pwdata[7:0] & 8'h77;
        end
        if (wr && pstrb[1]) begin
          dsel_nxt[15:8] = pwdata[15:8] & 8'h77;
        end
        if (setup) begin
          prdata_nxt = {16'h0, dsel_r};
        end
      end
      3'h5: begin
        if (setup) begin
          pslverr_nxt = pwrite;
          prdata_nxt  = {28'h0, g_out};
        end
      end
      default: begin
        if (setup) begin
          pslverr_nxt = 1'b1;
          prdata_nxt  = 32'h0;
        end
      end
    endcase
  end

  // Select registers hold through rst_n; only bus state resets
  always_ff @(posedge clk_sys) begin
    gsel_r <= gsel_nxt;
    dsel_r <= dsel_nxt;
    if (!rst_n) begin
      prdata_r  <= 32'h0;
      pslverr_r <= 1'b0;
    end else begin
      prdata_r  <= prdata_nxt;
      pslverr_r <= pslverr_nxt;
    end
  end

  // Four data selectors, each from its own window of sources
  lcgis_data_mux u_d1 (.src(cell_input_sources),
    .sel(dsel_r[DSEL1_LSB +: DSEL_W]), .base(DATA1_BASE),
    .data_true(d_true[0]), .data_inv(d_inv[0]));
  lcgis_data_mux u_d2 (.src(cell_input_sources),
    .sel(dsel_r[DSEL2_LSB +: DSEL_W]), .base(DATA2_BASE),
    .data_true(d_true[1]), .data_inv(d_inv[1]));
  lcgis_data_mux u_d3 (.src(cell_input_sources),
    .sel(dsel_r[DSEL3_LSB +: DSEL_W]), .base(DATA3_BASE),
    .data_true(d_true[2]), .data_inv(d_inv[2]));
  lcgis_data_mux u_d4 (.src(cell_input_sources),
    .sel(dsel_r[DSEL4_LSB +: DSEL_W]), .base(DATA4_BASE),
    .data_true(d_true[3]), .data_inv(d_inv[3]));

  // Four gates sharing one candidate layout
  lcgis_gate u_g1 (.sel(gsel_r[0]), .d_true(d_true), .d_inv(d_inv),
    .gate_out(g_out[0]));
  lcgis_gate u_g2 (.sel(gsel_r[1]), .d_true(d_true), .d_inv(d_inv),
    .gate_out(g_out[1]));
  lcgis_gate u_g3 (.sel(gsel_r[2]), .d_true(d_true), .d_inv(d_inv),
    .gate_out(g_out[2]));
  lcgis_gate u_g4 (.sel(gsel_r[3]), .d_true(d_true), .d_inv(d_inv),
    .gate_out(g_out[3]));

  // Gate outputs to the following stages
  assign gate_one_out   = g_out[0];
  assign gate_two_out   = g_out[1];
  assign gate_three_out = g_out[2];
  assign gate_four_out  = g_out[3];
endmodule

// [inc/lcgis_pkg.sv]
// Package for the logic cell gate input select block
package lcgis_pkg;
  localparam int          DATA_W      = 32;
  localparam int          ADDR_W      = 12;
  localparam int          SEL_W       = 8;
  localparam int          NUM_GATES   = 4;
  localparam int          NUM_DATA    = 4;
  localparam int          SRC_W       = 16;
  localparam int          DSEL_W      = 3;
  localparam int          CAND_PER    = 8;
  // Register byte addresses
  localparam logic [11:0] GATE1_SEL_ADDR = 12'h000;
  localparam logic [11:0] GATE2_SEL_ADDR = 12'h004;
  localparam logic [11:0] GATE3_SEL_ADDR = 12'h008;
  localparam logic [11:0] GATE4_SEL_ADDR = 12'h00c;
  localparam logic [11:0] DATA_SEL_ADDR  = 12'h010;
  localparam logic [11:0] GATE_OUT_ADDR  = 12'h014;
  // Base source index of each data selector
  localparam logic [3:0]  DATA1_BASE = 4'h0;
  localparam logic [3:0]  DATA2_BASE = 4'h4;
  localparam logic [3:0]  DATA3_BASE = 4'h8;
  localparam logic [3:0]  DATA4_BASE = 4'hc;
  // Field positions inside the data select register
  localparam int          DSEL1_LSB = 0;
  localparam int          DSEL2_LSB = 4;
  localparam int          DSEL3_LSB = 8;
  localparam int          DSEL4_LSB = 12;
endpackage

// [hw/lcgis_data_mux.sv]
// One data selector: three select bits pick one of eight sources
`timescale 1ns/100ps
module lcgis_data_mux (
  input  wire logic [lcgis_pkg::SRC_W-1:0]  src,
  input  wire logic [lcgis_pkg::DSEL_W-1:0] sel,
  input  wire logic [3:0]                   base,
  output logic                              data_true,
  output logic                              data_inv
);
  import lcgis_pkg::*;
  logic [3:0] idx;

  // Source index wraps around the sixteen inputs
  always_comb begin
    idx       = base + {1'b0, sel};
    data_true = src[idx];
    data_inv  = ~src[idx];
  end
endmodule

// [hw/lcgis_gate.sv]
// One gate: OR of all enabled true and inverted data candidates
`timescale 1ns/100ps
module lcgis_gate (
  input  wire logic [lcgis_pkg::SEL_W-1:0]    sel,
  input  wire logic [lcgis_pkg::NUM_DATA-1:0] d_true,
  input  wire logic [lcgis_pkg::NUM_DATA-1:0] d_inv,
  output logic                                gate_out
);
  import lcgis_pkg::*;
  logic [SEL_W-1:0] cand;

  // Candidate vector in register order, data 4 true at the top
  always_comb begin
    for (int i = 0; i < NUM_DATA; i++) begin
      cand[2*i+1] = d_true[i];
      cand[2*i]   = d_inv[i];
    end
    gate_out = |(cand & sel);
  end
endmodule

// [testbench/lcgis_top_sva.sv]
// Port checker for the gate input select block
`timescale 1ns/100ps
module lcgis_top_sva
  import lcgis_pkg::*;
(
  input wire logic        clk_sys,
  input wire logic        rst_n,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  input wire logic        gate_one_out,
  input wire logic        gate_two_out,
  input wire logic        gate_three_out,
  input wire logic        gate_four_out
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // Access phase of any transfer
  wire acc = psel & penable;
  wire wr0 = acc & pwrite & pstrb[0];
  // Error and read data stand in the access phase
  err_idle_a: assert property (!acc |-> !pslverr)
    else $error("error outside access phase");
  bad_addr_a: assert property (acc && paddr > 12'h014 |-> pslverr)
    else $error("no error on unmapped address");
  ro_write_a: assert property (wr0 && paddr == 12'h014 |-> pslverr)
    else $error("no error on output write");
  good_addr_a: assert property (acc && paddr < 12'h014
    && paddr[1:0] == 2'h0 |-> !pslverr) else $error("error on mapped address");
  gate_upper_a: assert property (acc && !pwrite && paddr < 12'h010
    |-> prdata[31:8] == 24'h0) else $error("gate read upper bits set");
  dsel_pad_a: assert property (acc && !pwrite && paddr == 12'h010
    |-> (prdata & 32'hffff8888) == 32'h0) else $error("pad bits set");
  // Gate values after a select write
  gate_none_a: assert property (wr0 && paddr == 12'h000
    && pwdata[7:0] == 8'h00 |=> !gate_one_out) else $error("empty gate high");
  gate_pair_a: assert property (wr0 && paddr == 12'h00c
    && pwdata[5:4] == 2'h3 |=> gate_four_out) else $error("pair gate low");
  gate_two_a: assert property (wr0 && paddr == 12'h004
    && pwdata[7:6] == 2'h3 |=> gate_two_out) else $error("gate two low");
  gate_three_a: assert property (wr0 && paddr == 12'h008
    && pwdata[1:0] == 2'h3 |=> gate_three_out) else $error("gate three low");
endmodule
bind lcgis_top lcgis_top_sva chk (.clk_sys, .rst_n, .psel, .penable,
  .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pslverr, .gate_one_out,
  .gate_two_out, .gate_three_out, .gate_four_out);

// [testbench/lcgis_top_bench.sv]
// Self-checking bench for the gate input select block
`timescale 1ns/100ps
module lcgis_top_bench;
  import lcgis_pkg::*;
  logic clk_sys, rst_n, psel, penable, pwrite, pready, pslverr, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r, seed;
  logic [3:0] pstrb;
  logic [15:0] cell_input_sources;
  logic gate_one_out, gate_two_out, gate_three_out, gate_four_out;
  int err_count, num_checks, i, g, dsm, sm;
  int gm[4];
  wire [3:0] go = {gate_four_out, gate_three_out, gate_two_out, gate_one_out};
  lcgis_top uut (.clk_sys, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pstrb, .prdata, .pready, .pslverr, .cell_input_sources, .gate_one_out,
    .gate_two_out, .gate_three_out, .gate_four_out);
  // Clock
  initial begin
    clk_sys = 0;
    forever #4 clk_sys = ~clk_sys;
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Reference gate: OR of enabled true and inverted candidates
  function automatic int gexp(int gs, int ds, int s);
    int k, d, o;
    o = 0;
    for (k = 0; k < 4; k++) begin
      d = (s >> ((4 * k + ((ds >> (4 * k)) & 7)) % 16)) & 1;
      o |= ((gs >> (2 * k + 1)) & d) | ((gs >> (2 * k)) & ~d & 1);
    end
    return o;
  endfunction
  task automatic chk(logic [31:0] got, logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  // One APB transfer; data and error taken at the completing edge
  task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
    @(posedge clk_sys);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wrap_up();
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Watchdog
  initial begin
    #100us;
    err_count++;
    wrap_up();
  end
  // Main sequence
  initial begin
    seed = 32'h5c; rst_n = 0; psel = 0; penable = 0; pwrite = 0;
    paddr = 0; pwdata = 0; pstrb = 4'hf; cell_input_sources = 0;
    repeat (6) @(posedge clk_sys);
    rst_n <= 1;
    for (i = 0; i < 30; i++) begin
      dsm = rnd() & 32'h7777;
      apb(1, 12'h010, dsm);
      chk(e, 0);
      for (g = 0; g < 4; g++) begin
        gm[g] = (i == 0) ? 0 : (i == 1) ? 8'hff : rnd() & 8'hff;
        apb(1, 12'(4 * g), gm[g]);
      end
      sm = rnd() & 16'hffff;
      @(posedge clk_sys);
      cell_input_sources <= sm[15:0];
      @(negedge clk_sys);
      for (g = 0; g < 4; g++) chk(go[g], gexp(gm[g], dsm, sm));
      if (i == 15) begin
        @(posedge clk_sys) rst_n <= 0;
        @(posedge clk_sys) rst_n <= 1;
      end
      for (g = 0; g < 4; g++) begin
        apb(0, 12'(4 * g), 0);
        chk(r, gm[g]);
      end
      apb(0, 12'h010, 0);
      chk(r, dsm);
    end
    apb(0, 12'h020, 0);
    chk(r, 0);
    chk(e, 1);
    apb(1, 12'h014, 5);
    chk(e, 1);
    wrap_up();
  end
endmodule
